// file: design/bies_exec.sv
// four phase execution unit for a subset of byte oriented instructions
`timescale 1ns/100ps
`default_nettype none
`include "bies_map.svh"

module bies_exec (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      instr_valid,
  input  wire logic [15:0]               instr,
  input  wire logic                      ext_set_en,
  input  wire logic [11:0]               index_base,
  input  wire logic                      acc_wr_en,
  input  wire logic [7:0]                acc_wr_data,
  input  wire logic                      bsr_wr_en,
  input  wire logic [3:0]                bsr_wr_data,
  input  wire logic [7:0]                mem_rdata,
  output bies_pkg::bies_mem_req_type     mem_req,
  output logic [7:0]                     acc,
  output bies_pkg::bies_flags_type       flags,
  output logic [3:0]                     bank_select_reg,
  output logic                           ready,
  output logic                           done
);
  import bies_pkg::*;

  bies_state_type st_reg;
  bies_state_type st_next;
  logic [7:0]     alu_operand;
  logic [7:0]     alu_result;
  bies_flags_type alu_flags;
  logic [7:0]     file_addr;
  logic           dest_file;
  logic           bank_bit;
  logic [11:0]    eff_addr;
  bies_op_type    dec_op;

  // instruction fields kept for the whole cycle
  assign file_addr = st_reg.instr[7:0];
  assign dest_file = st_reg.instr[`BIES_DEST_BIT];
  assign bank_bit  = st_reg.instr[`BIES_BANK_BIT];

  // opcode decode; anything else runs as a four phase no operation
  always_comb begin
    if (st_reg.instr[15:10] == `BIES_OPC_ADD_TOP) begin
      dec_op = BIES_OP_ADD_ACC_FILE_CARRY;
    end else if (st_reg.instr[15:10] == `BIES_OPC_ROT_TOP) begin
      dec_op = BIES_OP_ROTATE_RIGHT_NOCARRY_FILE;
    end else if (st_reg.instr[15:8] == `BIES_OPC_AND_TOP) begin
      dec_op = BIES_OP_AND_LITERAL_TO_ACC;
    end else if (st_reg.instr[15:9] == `BIES_OPC_SET_TOP) begin
      dec_op = BIES_OP_SET_FILE_ALL_ONES;
    end else begin
      dec_op = BIES_OP_NONE;
    end
  end

  // effective data address: indexed, access bank or selected bank
  always_comb begin
    if (bank_bit) begin
      eff_addr = {st_reg.bank_select_reg, file_addr};                      // RQ3
    end else if (ext_set_en && (file_addr <= `BIES_ACCESS_LIMIT)) begin
      // the indexed sum wraps inside the 12 bit data space on purpose
      eff_addr = 12'(index_base + {4'h0, file_addr});                      // RQ4
    end else if (file_addr <= `BIES_ACCESS_LIMIT) begin
      eff_addr = {4'h0, file_addr};                                        // RQ3
    end else begin
      eff_addr = {`BIES_ACCESS_HIGH_BANK, file_addr};                      // RQ3
    end
  end

  // literal op takes its operand from the word, the rest from memory
  assign alu_operand = (st_reg.op == BIES_OP_AND_LITERAL_TO_ACC) ? file_addr : mem_rdata;

  bies_alu u_alu (
    .op        (st_reg.op),
    .acc       (st_reg.acc),
    .operand   (alu_operand),
    .flags_in  (st_reg.flags),
    .result    (alu_result),
    .flags_out (alu_flags)
  );

  // phase sequencer; memory answers one clock after the read strobe
  always_comb begin
    st_next               = st_reg;
    st_next.done          = 1'b0;
    st_next.mem_req.rd_en = 1'b0;
    st_next.mem_req.wr_en = 1'b0;
    case (st_reg.phase)
      BIES_IDLE: begin
        // side loads only while idle so no instruction sees a torn value
        if (acc_wr_en) begin
          st_next.acc = acc_wr_data;
        end
        if (bsr_wr_en) begin
          st_next.bank_select_reg = bsr_wr_data;
        end
        if (instr_valid) begin
          st_next.instr = instr;
          st_next.phase = BIES_Q1_DECODE;                                  // RQ6
        end
      end
      BIES_Q1_DECODE: begin
        st_next.op            = dec_op;                                    // RQ6
        st_next.mem_req.addr  = eff_addr;
        st_next.mem_req.rd_en = (dec_op != BIES_OP_NONE) &&
                                (dec_op != BIES_OP_AND_LITERAL_TO_ACC);
        st_next.phase         = BIES_Q2_READ;
      end
      BIES_Q2_READ: begin
        st_next.phase = BIES_Q3_PROCESS;
      end
      BIES_Q3_PROCESS: begin
        st_next.operand = alu_operand;
        st_next.flags   = alu_flags;                                       // RQ1
        st_next.done    = 1'b1;
        st_next.phase   = BIES_Q4_WRITE;
        case (st_reg.op)
          BIES_OP_ADD_ACC_FILE_CARRY, BIES_OP_ROTATE_RIGHT_NOCARRY_FILE: begin
            if (dest_file) begin
              st_next.mem_req.wr_en = 1'b1;                                // RQ2
              st_next.mem_req.wdata = alu_result;
            end else begin
              st_next.acc = alu_result;                                    // RQ2
            end
          end
          BIES_OP_AND_LITERAL_TO_ACC: begin
            st_next.acc = alu_result;
          end
          BIES_OP_SET_FILE_ALL_ONES: begin
            st_next.mem_req.wr_en = 1'b1;
            st_next.mem_req.wdata = alu_result;
          end
          default: begin
            st_next.acc = st_reg.acc;
          end
        endcase
      end
      BIES_Q4_WRITE: begin
        st_next.phase = BIES_IDLE;                                         // RQ6
      end
      default: begin
        st_next.phase = BIES_IDLE;
      end
    endcase
    // ready kept as a flop so the output carries no decode glitch
    st_next.ready = (st_next.phase == BIES_IDLE);
  end

  // single state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg                 <= '0;
      st_reg.phase           <= BIES_IDLE;
      st_reg.op              <= BIES_OP_NONE;
      st_reg.acc             <= `BIES_ACC_RESET;
      st_reg.bank_select_reg <= `BIES_BSR_RESET;
      st_reg.mem_req.addr    <= `BIES_ADDR_RESET;
      st_reg.ready           <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign mem_req         = st_reg.mem_req;
  assign acc             = st_reg.acc;
  assign flags           = st_reg.flags;
  assign bank_select_reg = st_reg.bank_select_reg;
  assign ready           = st_reg.ready;
  assign done            = st_reg.done;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence take_s;
    (st_reg.phase == BIES_IDLE) && instr_valid;
  endsequence

  sequence four_phase_s;
    (st_reg.phase == BIES_Q1_DECODE) ##1 (st_reg.phase == BIES_Q2_READ) ##1
    (st_reg.phase == BIES_Q3_PROCESS) ##1 (st_reg.phase == BIES_Q4_WRITE && done) ##1
    (st_reg.phase == BIES_IDLE);
  endsequence

  cycle_phases_a: assert property (take_s |=> four_phase_s) // RQ6
    else $error("instruction did not run four phases");

  add_sum_a: assert property ((st_reg.phase == BIES_Q4_WRITE) &&
      (st_reg.op == BIES_OP_ADD_ACC_FILE_CARRY) && !dest_file |->
      acc == 8'($past(acc) + st_reg.operand + {7'h00, $past(flags.carry_flag)})) // RQ1
    else $error("add result in accumulator wrong");

  add_carry_a: assert property ((st_reg.phase == BIES_Q4_WRITE) &&
      (st_reg.op == BIES_OP_ADD_ACC_FILE_CARRY) |->
      flags.carry_flag == (({1'b0, $past(acc)} + {1'b0, st_reg.operand} +
      {8'h00, $past(flags.carry_flag)}) > 9'h0FF)) // RQ1
    else $error("add carry flag wrong");

  dest_file_a: assert property ((st_reg.phase == BIES_Q3_PROCESS) && dest_file &&
      (st_reg.op != BIES_OP_NONE) && (st_reg.op != BIES_OP_AND_LITERAL_TO_ACC) |=>
      mem_req.wr_en && $stable(acc)) // RQ2
    else $error("file destination not written");

  dest_acc_a: assert property ((st_reg.phase == BIES_Q3_PROCESS) && !dest_file &&
      (st_reg.op == BIES_OP_ROTATE_RIGHT_NOCARRY_FILE) |=> !mem_req.wr_en) // RQ2
    else $error("accumulator destination wrote memory");

  bank_addr_a: assert property ((st_reg.phase == BIES_Q2_READ) && bank_bit |->
      mem_req.addr == {bank_select_reg, file_addr}) // RQ3
    else $error("banked address wrong");

  // mode and base are taken in decode, so compare against their decode values
  indexed_addr_a: assert property ((st_reg.phase == BIES_Q2_READ) && !bank_bit &&
      $past(ext_set_en) && (file_addr <= `BIES_ACCESS_LIMIT) |->
      mem_req.addr == 12'($past(index_base) + {4'h0, file_addr})) // RQ4
    else $error("indexed literal offset address wrong");

  rotate_a: assert property ((st_reg.phase == BIES_Q4_WRITE) &&
      (st_reg.op == BIES_OP_ROTATE_RIGHT_NOCARRY_FILE) && dest_file |->
      mem_req.wdata == {st_reg.operand[0], st_reg.operand[7:1]} &&
      flags.carry_flag == $past(flags.carry_flag, 2) &&
      flags.overflow_flag == $past(flags.overflow_flag, 2)) // RQ5
    else $error("rotate result or flags wrong");

endmodule // bies_exec
`default_nettype wire

// file: design/bies_map.svh
// constants and offsets of the byte instruction execution subset
//
// Contract
// RQ1: add acc, file byte and carry; five flags
// RQ2: dest bit 0 to acc, 1 to file
// RQ3: bank bit 0 access bank, 1 bank select
// RQ4: extended set, f up to 5Fh uses index offset
// RQ5: rotate right, bit0 to bit7, only N,Z
// RQ6: one word, four phases: decode, read, process, write
`ifndef BIES_MAP_SVH
`define BIES_MAP_SVH

// opcode fields of the sixteen bit program word
`define BIES_OPC_ADD_TOP      6'h08
`define BIES_OPC_ROT_TOP      6'h10
`define BIES_OPC_AND_TOP      8'h0B
`define BIES_OPC_SET_TOP      7'h34
`define BIES_DEST_BIT         9
`define BIES_BANK_BIT         8

// access bank split and upper access window
`define BIES_ACCESS_LIMIT     8'h5F
`define BIES_ACCESS_HIGH_BANK 4'hF
`define BIES_ALL_ONES         8'hFF

// reset values
`define BIES_ACC_RESET        8'h00
`define BIES_BSR_RESET        4'h0
`define BIES_ADDR_RESET       12'h000

`endif

// file: design/bies_pkg.sv
// types of the byte instruction execution subset
`include "bies_map.svh"

package bies_pkg;

  typedef enum logic [2:0] {
    BIES_OP_NONE,
    BIES_OP_ADD_ACC_FILE_CARRY,
    BIES_OP_ROTATE_RIGHT_NOCARRY_FILE,
    BIES_OP_AND_LITERAL_TO_ACC,
    BIES_OP_SET_FILE_ALL_ONES
  } bies_op_type;

  typedef enum logic [2:0] {
    BIES_IDLE,
    BIES_Q1_DECODE,
    BIES_Q2_READ,
    BIES_Q3_PROCESS,
    BIES_Q4_WRITE
  } bies_phase_type;

  typedef struct packed {
    logic negative_flag;
    logic overflow_flag;
    logic zero_flag;
    logic digit_carry_flag;
    logic carry_flag;
  } bies_flags_type;

  // data memory request, one byte wide
  typedef struct packed {
    logic        rd_en;
    logic        wr_en;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } bies_mem_req_type;

  typedef struct packed {
    bies_phase_type   phase;
    logic [15:0]      instr;
    bies_op_type      op;
    logic [7:0]       acc;
    bies_flags_type   flags;
    logic [3:0]       bank_select_reg;
    logic [7:0]       operand;
    bies_mem_req_type mem_req;
    logic             done;
    logic             ready;
  } bies_state_type;

endpackage

// file: design/bies_alu.sv
// combinational byte datapath for the four supported operations
`timescale 1ns/100ps
`default_nettype none
`include "bies_map.svh"

module bies_alu (
  input  wire bies_pkg::bies_op_type    op,
  input  wire logic [7:0]               acc,
  input  wire logic [7:0]               operand,
  input  wire bies_pkg::bies_flags_type flags_in,
  output logic [7:0]                    result,
  output bies_pkg::bies_flags_type      flags_out
);
  import bies_pkg::*;

  logic [8:0] sum_full;
  logic [4:0] sum_low;

  // add with carry pieces, low nibble gives the digit carry
  assign sum_full = {1'b0, acc} + {1'b0, operand} + {8'h00, flags_in.carry_flag};
  assign sum_low  = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, flags_in.carry_flag};

  // result and flag update per operation; flags not named stay as they were
  always_comb begin
    result    = operand;
    flags_out = flags_in;
    case (op)
      BIES_OP_ADD_ACC_FILE_CARRY: begin
        result                     = sum_full[7:0];                     // RQ1
        flags_out.carry_flag       = sum_full[8];                       // RQ1
        flags_out.digit_carry_flag = sum_low[4];                        // RQ1
        flags_out.overflow_flag    = (acc[7] == operand[7]) &&
                                     (sum_full[7] != acc[7]);           // RQ1
        flags_out.negative_flag    = sum_full[7];
        flags_out.zero_flag        = (sum_full[7:0] == 8'h00);
      end
      BIES_OP_ROTATE_RIGHT_NOCARRY_FILE: begin
        // carry is deliberately untouched by this rotate
        result                  = {operand[0], operand[7:1]};           // RQ5
        flags_out.negative_flag = operand[0];                           // RQ5
        flags_out.zero_flag     = (operand == 8'h00);                   // RQ5
      end
      BIES_OP_AND_LITERAL_TO_ACC: begin
        result                  = acc & operand;
        flags_out.negative_flag = result[7];
        flags_out.zero_flag     = (result == 8'h00);
      end
      BIES_OP_SET_FILE_ALL_ONES: begin
        result = `BIES_ALL_ONES;
      end
      default: begin
        result    = operand;
        flags_out = flags_in;
      end
    endcase
  end

endmodule // bies_alu
`default_nettype wire

// file: dv/tb_byte_instr_exec_subset.sv
// self-checking bench for the byte instruction execution subset
`timescale 1ns/100ps
`default_nettype none

module tb_byte_instr_exec_subset;
  import bies_pkg::*;

  logic             clock;
  logic             rst;
  logic             instr_valid;
  logic [15:0]      instr;
  logic             ext_set_en;
  logic [11:0]      index_base;
  logic             acc_wr_en;
  logic [7:0]       acc_wr_data;
  logic             bsr_wr_en;
  logic [3:0]       bsr_wr_data;
  logic [7:0]       mem_rdata;
  bies_mem_req_type mem_req;
  logic [7:0]       acc;
  bies_flags_type   flags;
  logic [3:0]       bank_select_reg;
  logic             ready;
  logic             done;
  int               bad_count;
  int               compares;

  bies_exec uut (
    .clock(clock), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .ext_set_en(ext_set_en), .index_base(index_base), .acc_wr_en(acc_wr_en),
    .acc_wr_data(acc_wr_data), .bsr_wr_en(bsr_wr_en), .bsr_wr_data(bsr_wr_data),
    .mem_rdata(mem_rdata), .mem_req(mem_req), .acc(acc), .flags(flags),
    .bank_select_reg(bank_select_reg), .ready(ready), .done(done)
  );

  // free running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // four-state compare so an unknown never passes
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // side loads of accumulator and bank select, only legal while idle
  task automatic load(input logic [7:0] a, input logic [3:0] b);
    @(posedge clock);
    acc_wr_en   <= 1'b1;
    acc_wr_data <= a;
    bsr_wr_en   <= 1'b1;
    bsr_wr_data <= b;
    @(posedge clock);
    acc_wr_en <= 1'b0;
    bsr_wr_en <= 1'b0;
  endtask

  // one instruction walked phase by phase; read data only valid in Q3
  task automatic run(input logic [15:0] w, input logic [7:0] rd, input logic exp_rd,
                     input logic [11:0] exp_addr, input logic exp_wr, input logic [7:0] exp_wd,
                     input logic [7:0] exp_acc, input logic [4:0] exp_flags);
    @(posedge clock);
    instr_valid <= 1'b1;
    instr       <= w;
    @(posedge clock);
    instr_valid <= 1'b0;
    instr       <= ~w;
    #1 check("ready in decode", ready, 1'b0);
    @(posedge clock);
    acc_wr_en   <= 1'b1; // busy, so this load must be ignored
    acc_wr_data <= 8'h5A;
    #1 check("read strobe", mem_req.rd_en, exp_rd);
    if (exp_rd) check("read address", mem_req.addr, exp_addr);
    @(posedge clock);
    acc_wr_en <= 1'b0;
    mem_rdata <= rd;
    @(posedge clock);
    mem_rdata <= ~rd;
    #1 check("done in write phase", done, 1'b1);
    check("accumulator", acc, exp_acc);
    check("flags", flags, exp_flags);
    check("write strobe", mem_req.wr_en, exp_wr);
    if (exp_wr) check("write data", mem_req.wdata, exp_wd);
    if (exp_wr) check("write address", mem_req.addr, exp_addr);
    @(posedge clock);
    #1 check("done pulse length", done, 1'b0);
    check("write strobe length", mem_req.wr_en, 1'b0);
    check("ready after write", ready, 1'b1);
  endtask

  task automatic t_add_to_acc;
    load(8'hF0, 4'h0);
    run(16'h2010, 8'h25, 1'b1, 12'h010, 1'b0, 8'h00, 8'h15, 5'b00001);
    $display("test add_to_acc done");
  endtask

  // signed overflow, digit carry and carry-in all at once, banked address
  task automatic t_add_to_file;
    load(8'h3F, 4'h3);
    run(16'h237A, 8'h40, 1'b1, 12'h37A, 1'b1, 8'h80, 8'h3F, 5'b11010);
    $display("test add_to_file done");
  endtask

  // indexed sum wraps past 12 bits; carry must not take bit 0
  task automatic t_rotate_index;
    @(posedge clock);
    ext_set_en <= 1'b1;
    index_base <= 12'hFF0;
    run(16'h4220, 8'h03, 1'b1, 12'h010, 1'b1, 8'h81, 8'h3F, 5'b11010);
    $display("test rotate_index done");
  endtask

  // f just above the split goes to the upper access window
  task automatic t_rotate_high;
    run(16'h4060, 8'h00, 1'b1, 12'hF60, 1'b0, 8'h00, 8'h00, 5'b01110);
    $display("test rotate_high done");
  endtask

  task automatic t_and_literal;
    load(8'hA3, 4'h3);
    run(16'h0B5F, 8'h77, 1'b0, 12'h000, 1'b0, 8'h00, 8'h03, 5'b01010);
    $display("test and_literal done");
  endtask

  // f at the boundary still uses the index base
  task automatic t_set_ones;
    @(posedge clock);
    index_base <= 12'h100;
    run(16'h685F, 8'h12, 1'b1, 12'h15F, 1'b1, 8'hFF, 8'h03, 5'b01010);
    $display("test set_ones done");
  endtask

  // unknown word: four phases, no read, no write, acc and flags kept
  task automatic t_unknown;
    run(16'hF000, 8'h99, 1'b0, 12'h000, 1'b0, 8'h00, 8'h03, 5'b01010);
    $display("test unknown done");
  endtask

  // main sequence
  initial begin
    rst         = 1'b1;
    instr_valid = 1'b0;
    instr       = 16'h0000;
    ext_set_en  = 1'b0;
    index_base  = 12'h000;
    acc_wr_en   = 1'b0;
    acc_wr_data = 8'h00;
    bsr_wr_en   = 1'b0;
    bsr_wr_data = 4'h0;
    mem_rdata   = 8'h00;
    bad_count   = 0;
    compares    = 0;
    repeat (2) @(posedge clock);
    #1 check("reset acc", acc, 8'h00);
    check("reset flags", flags, 5'b00000);
    check("reset ready", ready, 1'b1);
    check("reset bank select", bank_select_reg, 4'h0);
    @(posedge clock);
    rst <= 1'b0;
    t_add_to_acc();
    t_add_to_file();
    t_rotate_index();
    t_rotate_high();
    t_and_literal();
    t_set_ones();
    t_unknown();
    conclude();
  end

  // run needs well under 100 cycles, so 2000 means a hang
  initial begin
    #20000;
    bad_count++;
    $display("Error watchdog expired before the tests ended");
    conclude();
  end

endmodule // tb_byte_instr_exec_subset

`default_nettype wire
